// ---- hdl/smc_pkg.sv ----
// Constants, modes and timing for the standby mode controller.
// Assumes a single 50 MHz system clock and an active-low asynchronous reset.
// Contract
// - Pause state stops instruction execution; peripherals keep running.
// - Pause state stops parts of the serial transfer logic.
// - Entering pause state leaves every oscillator as it was.
// - Pause state ends on system reset or any interrupt.
// - Deep-stop suspends instruction execution and every peripheral.
// - Deep-stop halts ceramic, internal RC, crystal and multi-frequency RC oscillators.
// - Deep-stop exits only on reset pin low, ext irq a/b/c level, port 0.
// - Crystal-keeping stop runs only base timer and remote receiver.
// - Crystal-keeping stop halts ceramic, internal RC, multi-frequency RC oscillators.
// - Crystal-keeping stop keeps crystal oscillator state from entry.
// - Crystal-keeping stop exits on reset, ext irq, port 0, base timer, remote.
// - Crystal clock used as system clock may be multiplied by two or three.
// - Every port 0 pin wakes deep-stop and raises port 0 interrupt; the controller does this only for pins set in port0_irq_en.
// - First external interrupt input is carried on port 7 bit 0.
package smc_pkg;

  typedef enum logic [2:0] {
    SMC_RUN,
    SMC_PAUSE,
    SMC_DEEP_STOP,
    SMC_XTAL_STOP,
    SMC_WARMUP
  } smc_state_type;

  // Standby request codes from the CPU core
  localparam logic [1:0] SMC_REQ_NONE  = 2'h0;
  localparam logic [1:0] SMC_REQ_PAUSE = 2'h1;
  localparam logic [1:0] SMC_REQ_DEEP  = 2'h2;
  localparam logic [1:0] SMC_REQ_XTAL  = 2'h3;

  // Multiplier codes
  localparam logic [1:0] SMC_MULT_X1 = 2'h1;
  localparam logic [1:0] SMC_MULT_X2 = 2'h2;
  localparam logic [1:0] SMC_MULT_X3 = 2'h3;

  localparam int SMC_CLK_HZ        = 50_000_000;
  localparam int SMC_WARMUP_US     = 100;
  localparam int SMC_WARMUP_CYCLES = (SMC_WARMUP_US * (SMC_CLK_HZ / 1_000_000));

  localparam int SMC_P0_WIDTH   = 8;
  localparam int SMC_P7_WIDTH   = 4;
  localparam int SMC_EXT_IRQ_A_BIT = 0;
  localparam int SMC_EXT_IRQ_B_BIT = 1;
  localparam int SMC_EXT_IRQ_C_BIT = 2;

  localparam logic [3:0] SMC_OSC_RESET = 4'hf;
  localparam logic       SMC_RESET_ZERO = 1'b0;

endpackage

// ---- hdl/smc_sync.sv ----
// Two-flop synchroniser bank for asynchronous wake inputs.
// Assumes inputs come from pins outside the system clock domain.
`timescale 1ns/1ps
module smc_sync import smc_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[i] <= SMC_RESET_ZERO;
          sync_reg[i] <= SMC_RESET_ZERO;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule

// ---- hdl/smc_top.sv ----
// Standby mode controller: pause, deep-stop and crystal-keeping stop.
// Assumes CPU requests are on ref_clk; pins and reset pin are asynchronous.
`timescale 1ns/1ps
module smc_top import smc_pkg::*; #(
  parameter int P0_WIDTH      = SMC_P0_WIDTH,
  parameter int P7_WIDTH      = SMC_P7_WIDTH,
  parameter int WARMUP_CYCLES = SMC_WARMUP_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                reset_pin_n,
  input  wire logic [1:0]          standby_req,
  input  wire logic                standby_req_valid,
  input  wire logic                cpu_irq,
  input  wire logic [P7_WIDTH-1:0] port7_in,
  input  wire logic [2:0]          ext_irq_level,
  input  wire logic [2:0]          ext_irq_en,
  input  wire logic [P0_WIDTH-1:0] port0_in,
  input  wire logic [P0_WIDTH-1:0] port0_irq_en,
  input  wire logic                base_timer_irq,
  input  wire logic                remote_rx_irq,
  input  wire logic                xtal_sysclk_sel,
  input  wire logic [1:0]          mult_sel,
  input  wire logic [3:0]          osc_run_req,
  output logic                     cpu_run,
  output logic                     periph_run,
  output logic                     serial_run,
  output logic                     base_timer_run,
  output logic                     remote_rx_run,
  output logic                     ceramic_osc_en,
  output logic                     internal_rc_osc_en,
  output logic                     xtal_osc_en,
  output logic                     mfrc_osc_en,
  output logic [1:0]               clk_mult,
  output logic                     port0_irq,
  output logic                     wake_event,
  output logic [2:0]               standby_state
);

  localparam int CW = $clog2(WARMUP_CYCLES + 1);

  logic [P7_WIDTH-1:0] p7_s;
  logic [P0_WIDTH-1:0] p0_s;
  logic [2:0]          misc_s;
  logic                rst_pin_s;
  logic [2:0]          ext_hit;
  logic                p0_hit;
  logic                pause_wake;
  logic                deep_wake;
  logic                xtal_wake;

  smc_sync #(.WIDTH(P7_WIDTH)) u_sync_p7 (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in (port7_in),
    .sync_out (p7_s)
  );

  // Fed inverted: reset reads as pins idle high, no false wake after reset
  smc_sync #(.WIDTH(P0_WIDTH)) u_sync_p0 (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in (~port0_in),
    .sync_out (p0_s)
  );

  smc_sync #(.WIDTH(3)) u_sync_misc (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in ({~reset_pin_n, base_timer_irq, remote_rx_irq}),
    .sync_out (misc_s)
  );

  // Reset pin synced inverted so flop reset does not read as pin low
  assign rst_pin_s = ~misc_s[2];

  // ext irq a on port 7 bit 0
  assign ext_hit[0] = ext_irq_en[0] & (p7_s[SMC_EXT_IRQ_A_BIT] == ext_irq_level[0]);
  assign ext_hit[1] = ext_irq_en[1] & (p7_s[SMC_EXT_IRQ_B_BIT] == ext_irq_level[1]);
  assign ext_hit[2] = ext_irq_en[2] & (p7_s[SMC_EXT_IRQ_C_BIT] == ext_irq_level[2]);

  // any enabled port 0 pin low
  assign p0_hit = |(p0_s & port0_irq_en);

  // pause exits on reset or interrupt
  assign pause_wake = ~rst_pin_s | cpu_irq | (|ext_hit) | p0_hit | misc_s[1] | misc_s[0];
  assign deep_wake  = ~rst_pin_s | (|ext_hit) | p0_hit;
  assign xtal_wake  = deep_wake | misc_s[1] | misc_s[0];

  smc_state_type   state_reg;
  smc_state_type   state_next;
  logic [CW-1:0]   cnt_reg;
  logic [CW-1:0]   cnt_next;
  logic [3:0]      osc_reg;
  logic [3:0]      osc_next;
  logic            xtal_keep_reg;
  logic            xtal_keep_next;
  logic            cpu_run_reg;
  logic            cpu_run_next;
  logic            periph_reg;
  logic            periph_next;
  logic            serial_reg;
  logic            serial_next;
  logic            bt_reg;
  logic            bt_next;
  logic [1:0]      mult_reg;
  logic [1:0]      mult_next;
  logic            p0irq_reg;
  logic            p0irq_next;
  logic            wake_reg;
  logic            wake_next;

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    osc_next       = osc_reg;
    xtal_keep_next = xtal_keep_reg;
    wake_next      = 1'b0;
    p0irq_next     = p0_hit;
    mult_next      = SMC_MULT_X1;
    // two or three times on crystal
    if (xtal_sysclk_sel && (mult_sel == SMC_MULT_X2 || mult_sel == SMC_MULT_X3)) begin
      mult_next = mult_sel;
    end
    unique case (state_reg)
      SMC_RUN: begin
        osc_next = osc_run_req;
        if (standby_req_valid) begin
          unique case (standby_req)
            SMC_REQ_NONE: begin
            end
            SMC_REQ_PAUSE: begin
              state_next = SMC_PAUSE;
              osc_next   = osc_reg;
            end
            SMC_REQ_DEEP: begin
              state_next = SMC_DEEP_STOP;
              osc_next   = 4'h0;
            end
            SMC_REQ_XTAL: begin
              state_next     = SMC_XTAL_STOP;
              xtal_keep_next = osc_reg[2];
              osc_next       = {1'b0, osc_reg[2], 2'b00};
            end
          endcase
        end
      end
      SMC_PAUSE: begin
        if (pause_wake) begin
          state_next = SMC_RUN;
          wake_next  = 1'b1;
        end
      end
      SMC_DEEP_STOP: begin
        if (deep_wake) begin
          state_next = SMC_WARMUP;
          osc_next   = osc_run_req;
          cnt_next   = CW'(WARMUP_CYCLES);
        end
      end
      SMC_XTAL_STOP: begin
        osc_next = {1'b0, xtal_keep_reg, 2'b00};
        if (xtal_wake) begin
          state_next = SMC_WARMUP;
          osc_next   = osc_run_req;
          cnt_next   = CW'(WARMUP_CYCLES);
        end
      end
      SMC_WARMUP: begin
        if (cnt_reg == '0) begin
          state_next = SMC_RUN;
          wake_next  = 1'b1;
        end else begin
          cnt_next = cnt_reg - CW'(1);
        end
      end
    endcase
    // Reset pin forces run; oscillators restart without warm-up wait
    if (!rst_pin_s) begin
      state_next = SMC_RUN;
      osc_next   = SMC_OSC_RESET;
      cnt_next   = '0;
    end
    // CPU runs only in run state
    cpu_run_next = (state_next == SMC_RUN);
    periph_next  = (state_next == SMC_RUN) || (state_next == SMC_PAUSE);
    serial_next  = (state_next == SMC_RUN);
    // base timer and remote also keep running in crystal-keeping stop
    bt_next      = periph_next || (state_next == SMC_XTAL_STOP);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= SMC_RUN;
      cnt_reg       <= '0;
      osc_reg       <= SMC_OSC_RESET;
      xtal_keep_reg <= 1'b0;
      cpu_run_reg   <= 1'b1;
      periph_reg    <= 1'b1;
      serial_reg    <= 1'b1;
      bt_reg        <= 1'b1;
      mult_reg      <= SMC_MULT_X1;
      p0irq_reg     <= 1'b0;
      wake_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      osc_reg       <= osc_next;
      xtal_keep_reg <= xtal_keep_next;
      cpu_run_reg   <= cpu_run_next;
      periph_reg    <= periph_next;
      serial_reg    <= serial_next;
      bt_reg        <= bt_next;
      mult_reg      <= mult_next;
      p0irq_reg     <= p0irq_next;
      wake_reg      <= wake_next;
    end
  end

  assign cpu_run            = cpu_run_reg;
  assign periph_run         = periph_reg;
  assign serial_run         = serial_reg;
  assign base_timer_run     = bt_reg;
  assign remote_rx_run      = bt_reg;
  assign ceramic_osc_en     = osc_reg[0];
  assign internal_rc_osc_en = osc_reg[1];
  assign xtal_osc_en        = osc_reg[2];
  assign mfrc_osc_en        = osc_reg[3];
  assign clk_mult           = mult_reg;
  assign port0_irq          = p0irq_reg;
  assign wake_event         = wake_reg;
  assign standby_state      = state_reg;

endmodule

// ---- verification/smc_cpu_model.sv ----
// CPU core stand-in: turns a bench strobe into a one-cycle request.
// Assumes go is raised for a single ref_clk cycle at a time.
`timescale 1ns/1ps
module smc_cpu_model import smc_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic [1:0] code,
  output logic      [1:0] standby_req,
  output logic            standby_req_valid
);
  // Code drops to none outside the pulse, never left stale
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_req       <= SMC_REQ_NONE;
      standby_req_valid <= 1'b0;
    end else begin
      standby_req       <= go ? code : SMC_REQ_NONE;
      standby_req_valid <= go;
    end
  end
endmodule

// ---- verification/smc_props.sv ----
// Port checker for the standby mode controller.
// Assumes mode inputs held steady by the bench; bound into smc_top.
`timescale 1ns/1ps
module smc_props import smc_pkg::*; #(
  parameter int WARMUP_CYCLES = SMC_WARMUP_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cpu_irq,
  input wire logic       xtal_sysclk_sel,
  input wire logic [1:0] mult_sel,
  input wire logic       cpu_run,
  input wire logic       periph_run,
  input wire logic       serial_run,
  input wire logic       base_timer_run,
  input wire logic       remote_rx_run,
  input wire logic       ceramic_osc_en,
  input wire logic       internal_rc_osc_en,
  input wire logic       xtal_osc_en,
  input wire logic       mfrc_osc_en,
  input wire logic [1:0] clk_mult,
  input wire logic       wake_event,
  input wire logic [2:0] standby_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] osc;
  assign osc = {mfrc_osc_en, xtal_osc_en, internal_rc_osc_en, ceramic_osc_en};

  pause_run_a: assert property (
    standby_state == 3'h1 |-> !cpu_run && periph_run && !serial_run) else $error("pause flags");
  pause_osc_a: assert property (
    standby_state == 3'h1 && $past(standby_state) == 3'h0 |-> osc == $past(osc))
    else $error("pause entry moved an oscillator");
  pause_exit_a: assert property (
    standby_state == 3'h1 && cpu_irq |=> standby_state == 3'h0 && wake_event)
    else $error("pause did not end on interrupt");
  deep_halt_a: assert property (
    standby_state == 3'h2 |-> !cpu_run && !periph_run && osc == 4'h0) else $error("deep halt");
  xtal_halt_a: assert property (
    standby_state == 3'h3 |-> !cpu_run && !periph_run && base_timer_run && remote_rx_run
      && (osc & 4'hb) == 4'h0) else $error("crystal stop halt");
  xtal_keep_a: assert property (
    standby_state == 3'h3 |-> $stable(xtal_osc_en)) else $error("crystal state changed");
  // Warm-up span counted here; too long for a repetition at the default length
  int warm_cnt;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_cnt <= 0;
    end else if (standby_state == 3'h4) begin
      warm_cnt <= warm_cnt + 1;
    end else begin
      warm_cnt <= 0;
    end
  end
  warm_done_a: assert property (
    $fell(standby_state == 3'h4) && wake_event |-> warm_cnt == WARMUP_CYCLES + 1
      && cpu_run && standby_state == 3'h0) else $error("warm-up length");
  mult_pick_a: assert property (
    $past(arst_n) && xtal_sysclk_sel && mult_sel[1] && $stable(mult_sel)
      && $stable(xtal_sysclk_sel) |-> clk_mult == mult_sel) else $error("multiplier");
endmodule

bind smc_top smc_props #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_smc_props (.*);

// ---- verification/test_standby_mode_controller.sv ----
// Self-checking bench for the standby mode controller.
// Assumes a short warm-up count and pins driven straight by the bench.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_standby_mode_controller import smc_pkg::*; ();
  int         n_mismatch = 0;
  int         checks_done = 0;
  logic       ref_clk = 1'b0;
  logic       arst_n;
  logic       go = 1'b0, reset_pin_n = 1'b1, cpu_irq = 1'b0, xtal_sysclk_sel = 1'b0;
  logic       base_timer_irq = 1'b0, remote_rx_irq = 1'b0;
  logic [1:0] code = 2'h0, mult_sel = 2'h1, standby_req, clk_mult;
  logic [2:0] ext_irq_level = 3'h1, ext_irq_en = 3'h1, standby_state;
  logic [3:0] port7_in = 4'h0, osc_run_req = 4'h5, osc;
  logic [7:0] port0_in = 8'hff, port0_irq_en = 8'h80;
  logic       standby_req_valid, cpu_run, periph_run, serial_run, base_timer_run;
  logic       remote_rx_run, ceramic_osc_en, internal_rc_osc_en, xtal_osc_en, mfrc_osc_en;
  logic       port0_irq, wake_event;

  assign osc = {mfrc_osc_en, xtal_osc_en, internal_rc_osc_en, ceramic_osc_en};
  always #10 ref_clk = ~ref_clk;
  smc_cpu_model u_smc_cpu_model (.*);
  // Short warm-up keeps the run brief
  smc_top #(.WARMUP_CYCLES(4)) u_smc_top (.*);

  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic enter(logic [1:0] c);
    tick();
    go   <= 1'b1;
    code <= c;
    tick();
    go <= 1'b0;
    tick();
    #1;
  endtask
  task automatic wait_st(logic [2:0] s);
    for (int i = 0; i < 50 && standby_state !== s; i++) begin
      tick();
      #1;
    end
    `CHK(standby_state, s)
  endtask
  task automatic t_pause;
    enter(SMC_REQ_PAUSE);
    `CHK({cpu_run, periph_run, serial_run}, 3'h2)
    `CHK(osc, 4'h5)
    tick();
    cpu_irq <= 1'b1;
    tick();
    cpu_irq <= 1'b0;
    #1;
    `CHK({standby_state, wake_event}, 4'h1)
  endtask
  task automatic t_deep;
    enter(SMC_REQ_DEEP);
    `CHK({cpu_run, periph_run, osc}, 6'h00)
    tick();
    cpu_irq        <= 1'b1;
    base_timer_irq <= 1'b1;
    remote_rx_irq  <= 1'b1;
    tick(6);
    #1;
    `CHK(standby_state, 3'h2)
    tick();
    cpu_irq        <= 1'b0;
    base_timer_irq <= 1'b0;
    remote_rx_irq  <= 1'b0;
    port7_in       <= 4'h1;
    wait_st(3'h4);
    `CHK({cpu_run, osc}, 5'h05)
    tick();
    port7_in <= 4'h0;
    wait_st(3'h0);
    `CHK(wake_event, 1'b1)
  endtask
  task automatic t_port0;
    enter(SMC_REQ_DEEP);
    tick();
    port0_in <= 8'h7f;
    wait_st(3'h4);
    `CHK(port0_irq, 1'b1)
    tick();
    port0_in <= 8'hff;
    wait_st(3'h0);
    `CHK(port0_irq, 1'b0)
  endtask
  task automatic t_xtal;
    for (int k = 0; k < 2; k++) begin
      tick();
      osc_run_req <= k ? 4'h1 : 4'hf;
      tick(2);
      enter(SMC_REQ_XTAL);
      `CHK({base_timer_run, remote_rx_run, cpu_run, periph_run}, 4'hc)
      `CHK(osc, k ? 4'h0 : 4'h4)
      tick();
      base_timer_irq <= !k;
      remote_rx_irq  <= k[0];
      wait_st(3'h4);
      tick();
      base_timer_irq <= 1'b0;
      remote_rx_irq  <= 1'b0;
      wait_st(3'h0);
    end
    tick();
    osc_run_req <= 4'h5;
  endtask
  task automatic t_mult;
    xtal_sysclk_sel <= 1'b1;
    for (int m = 2; m < 4; m++) begin
      tick();
      mult_sel <= m[1:0];
      tick(3);
      #1;
      `CHK(clk_mult, m[1:0])
    end
    tick();
    xtal_sysclk_sel <= 1'b0;
    mult_sel        <= 2'h1;
    tick(3);
    #1;
    `CHK(clk_mult, SMC_MULT_X1)
  endtask
  task automatic t_pin;
    enter(SMC_REQ_DEEP);
    tick();
    reset_pin_n <= 1'b0;
    tick(4);
    #1;
    `CHK({standby_state, osc}, 7'h0f)
    tick();
    reset_pin_n <= 1'b1;
    tick(4);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_pause();
    t_deep();
    t_port0();
    t_xtal();
    t_mult();
    t_pin();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
endmodule
